/* File: shared/swsl_cfg.svh */
// timing figures and command codes for the single-wire slave link
// assumes a 50 MHz ref_clk; every figure is a least time, rounded up
`ifndef SWSL_CFG_SVH
`define SWSL_CFG_SVH

`define SWSL_CLK_NS          20
`define SWSL_CYC(ns)         ((((ns) + `SWSL_CLK_NS - 1) / `SWSL_CLK_NS))

// low pulse seen as reset
`define SWSL_T_RST_STD_NS    120000
`define SWSL_T_RST_OD_NS     15500
// low pulse that also ends overdrive
`define SWSL_T_OD_CLR_NS     480000
// write bit sample point after the fall
`define SWSL_T_SAMP_STD_NS   15000
`define SWSL_T_SAMP_OD_NS    2000
// presence high delay and presence low duration
`define SWSL_T_PDH_STD_NS    30000
`define SWSL_T_PDH_OD_NS     3000
`define SWSL_T_PDL_STD_NS    120000
`define SWSL_T_PDL_OD_NS     12000
// how long a read zero is held after the fall
`define SWSL_T_RD0_STD_NS    30000
`define SWSL_T_RD0_OD_NS     3000
// slot recovery time
`define SWSL_T_REC_STD_NS    5000
`define SWSL_T_REC_OD_NS     2000

`define SWSL_RST_OD_CYC      16'(`SWSL_CYC(`SWSL_T_RST_OD_NS))
`define SWSL_SAMP_STD_CYC    16'(`SWSL_CYC(`SWSL_T_SAMP_STD_NS))
`define SWSL_SAMP_OD_CYC     16'(`SWSL_CYC(`SWSL_T_SAMP_OD_NS))
`define SWSL_PDH_STD_CYC     16'(`SWSL_CYC(`SWSL_T_PDH_STD_NS))
`define SWSL_PDH_OD_CYC      16'(`SWSL_CYC(`SWSL_T_PDH_OD_NS))
`define SWSL_PDL_OD_CYC      16'(`SWSL_CYC(`SWSL_T_PDL_OD_NS))
`define SWSL_RD0_STD_CYC     16'(`SWSL_CYC(`SWSL_T_RD0_STD_NS))
`define SWSL_RD0_OD_CYC      16'(`SWSL_CYC(`SWSL_T_RD0_OD_NS))
`define SWSL_REC_STD_CYC     16'(`SWSL_CYC(`SWSL_T_REC_STD_NS))
`define SWSL_REC_OD_CYC      16'(`SWSL_CYC(`SWSL_T_REC_OD_NS))

// addressing command codes
`define SWSL_CMD_MATCH       8'h55
`define SWSL_CMD_SEARCH      8'hF0
`define SWSL_CMD_SKIP        8'hCC
`define SWSL_CMD_RESUME      8'hA5
`define SWSL_CMD_OD_SKIP     8'h3C
`define SWSL_CMD_OD_MATCH    8'h69

`define SWSL_FIFO_WIDTH      8
`define SWSL_FIFO_DEPTH      8
`define SWSL_CNT_MAX         16'hFFFF

`endif

/* File: shared/swsl_pkg.sv */
// types for the single-wire slave link
// assumes swsl_cfg.svh is compiled alongside
package swsl_pkg;

    typedef enum logic [2:0] {
        SWSL_S_IDLE = 3'b000,
        SWSL_S_LOW  = 3'b001,
        SWSL_S_PDH  = 3'b010,
        SWSL_S_PDL  = 3'b011,
        SWSL_S_REC  = 3'b100
    } swsl_slot_t;

    typedef enum logic [2:0] {
        SWSL_P_WAIT   = 3'b000,
        SWSL_P_CMD    = 3'b001,
        SWSL_P_MATCH  = 3'b010,
        SWSL_P_SEARCH = 3'b011,
        SWSL_P_MEM    = 3'b100
    } swsl_phase_t;

    typedef struct packed {
        swsl_slot_t  slot;
        swsl_phase_t phase;
        logic [15:0] cnt;
        logic        line_prev;
        logic        bit_val;
        logic        drive_zero;
        logic        oe_n;
        logic        low_lvl;
        logic        od;
        logic        od_prev;
        logic        od_match;
        logic        rc;
        logic        mism;
        logic [5:0]  idx;
        logic [2:0]  bcnt;
        logic [1:0]  trip;
        logic [7:0]  shreg;
        logic [7:0]  pend;
        logic        pend_vld;
        logic        ovf;
        logic        pres;
        logic        granted;
    } swsl_state_t;

endpackage

/* File: hw/swsl_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/10ps
module swsl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // draining side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // depth must be a power of two so the pointers wrap by themselves
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               count;
    } swsl_fifo_state_t;

    swsl_fifo_state_t st_ff;
    swsl_fifo_state_t nxt_st;
    logic             push;
    logic             pop;

    assign in_ready  = (st_ff.count != CW'(DEPTH));
    assign out_valid = (st_ff.count != '0);
    assign out_data  = st_ff.mem[st_ff.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

/* File: hw/swsl_link.sv */
// slave end of a single-wire open-drain link: slot timing, reset and
// presence, addressing commands, overdrive and resume selection
// assumes line_in is already synchronous to ref_clk and that the pad
// resolves line_out/line_oe_n into the wired-and bus level
`timescale 1ns/10ps
`include "swsl_cfg.svh"
module swsl_link #(
    parameter logic [15:0] RST_STD_CYC = 16'(`SWSL_CYC(`SWSL_T_RST_STD_NS)),
    parameter logic [15:0] OD_CLR_CYC  = 16'(`SWSL_CYC(`SWSL_T_OD_CLR_NS)),
    parameter logic [15:0] PDL_STD_CYC = 16'(`SWSL_CYC(`SWSL_T_PDL_STD_NS))
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // open-drain bus pin
    input  wire logic        line_in,
    output logic             line_out,
    output logic             line_oe_n,
    // device identifier, held static
    input  wire logic [63:0] rom_id,
    // memory function byte stream
    output logic [7:0]       mem_data,
    output logic             mem_valid,
    input  wire logic        mem_ready,
    // status
    output logic             od_flag,
    output logic             resume_select_flag,
    output logic             mem_access,
    output logic             presence_sent,
    output logic             mem_overflow
);
    swsl_pkg::swsl_state_t st_ff;
    swsl_pkg::swsl_state_t nxt_st;
    logic                  fifo_in_ready;
    logic                  line_fall;
    logic                  bit_done;
    logic                  bv;
    logic                  tx_zero;
    logic                  id_bit;
    logic [7:0]            rx_byte;
    logic [15:0]           t_rst;
    logic [15:0]           t_samp;
    logic [15:0]           t_pdh;
    logic [15:0]           t_pdl;
    logic [15:0]           t_rd0;
    logic [15:0]           t_rec;

    // pick the standard or the overdrive figure
    function automatic logic [15:0] swsl_pick(input logic od, input logic [15:0] std_v, input logic [15:0] od_v);
        swsl_pick = od ? od_v : std_v;
    endfunction

    assign t_rst  = swsl_pick(st_ff.od, RST_STD_CYC, `SWSL_RST_OD_CYC);
    assign t_samp = swsl_pick(st_ff.od, `SWSL_SAMP_STD_CYC, `SWSL_SAMP_OD_CYC);
    assign t_pdh  = swsl_pick(st_ff.od, `SWSL_PDH_STD_CYC, `SWSL_PDH_OD_CYC);
    assign t_pdl  = swsl_pick(st_ff.od, PDL_STD_CYC, `SWSL_PDL_OD_CYC);
    assign t_rd0  = swsl_pick(st_ff.od, `SWSL_RD0_STD_CYC, `SWSL_RD0_OD_CYC);
    assign t_rec  = swsl_pick(st_ff.od, `SWSL_REC_STD_CYC, `SWSL_REC_OD_CYC);

    assign id_bit    = rom_id[st_ff.idx];
    assign line_fall = st_ff.line_prev & ~line_in;
    assign rx_byte   = {bv, st_ff.shreg[7:1]};

    assign tx_zero = (st_ff.phase == swsl_pkg::SWSL_P_SEARCH) &&
                     (((st_ff.trip == 2'd0) && !id_bit) || ((st_ff.trip == 2'd1) && id_bit));

    always_comb begin
        nxt_st           = st_ff;
        bit_done         = 1'b0;
        bv               = st_ff.drive_zero ? 1'b0 : st_ff.bit_val;
        nxt_st.line_prev = line_in;
        nxt_st.pres      = 1'b0;
        nxt_st.low_lvl   = 1'b0;
        if (st_ff.pend_vld && fifo_in_ready) begin
            nxt_st.pend_vld = 1'b0;
        end
        case (st_ff.slot)
            swsl_pkg::SWSL_S_IDLE: begin
                if (line_fall) begin
                    nxt_st.slot       = swsl_pkg::SWSL_S_LOW;
                    nxt_st.cnt        = 16'h0001;
                    nxt_st.bit_val    = 1'b1;
                    // drive only inside a master slot
                    nxt_st.drive_zero = tx_zero;
                    nxt_st.oe_n       = ~tx_zero;
                end
            end
            swsl_pkg::SWSL_S_LOW: begin
                if (st_ff.cnt != `SWSL_CNT_MAX) begin
                    nxt_st.cnt = st_ff.cnt + 16'h0001;
                end
                // release read zero at timer end
                if (st_ff.drive_zero && st_ff.cnt >= t_rd0) begin
                    nxt_st.oe_n = 1'b1;
                end
                if (!st_ff.drive_zero && st_ff.cnt == t_samp) begin
                    nxt_st.bit_val = line_in;
                end
                if (line_in && st_ff.oe_n) begin
                    nxt_st.cnt = 16'h0000;
                    if (st_ff.cnt >= t_rst) begin
                        nxt_st.slot  = swsl_pkg::SWSL_S_PDH;
                        nxt_st.phase = swsl_pkg::SWSL_P_CMD;
                        nxt_st.bcnt  = 3'd0;
                        nxt_st.idx   = 6'd0;
                        nxt_st.trip  = 2'd0;
                        nxt_st.mism  = 1'b0;
                        nxt_st.ovf   = 1'b0;
                        if (st_ff.cnt >= OD_CLR_CYC) begin
                            nxt_st.od = 1'b0;
                        end
                    end else begin
                        bit_done    = 1'b1;
                        nxt_st.slot = swsl_pkg::SWSL_S_REC;
                    end
                end
            end
            swsl_pkg::SWSL_S_PDH: begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                if (st_ff.cnt >= t_pdh) begin
                    nxt_st.slot = swsl_pkg::SWSL_S_PDL;
                    nxt_st.cnt  = 16'h0000;
                    nxt_st.oe_n = 1'b0;
                    nxt_st.pres = 1'b1;
                end
            end
            swsl_pkg::SWSL_S_PDL: begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                if (st_ff.cnt >= t_pdl) begin
                    nxt_st.slot = swsl_pkg::SWSL_S_REC;
                    nxt_st.cnt  = 16'h0000;
                    nxt_st.oe_n = 1'b1;
                end
            end
            swsl_pkg::SWSL_S_REC: begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                if (st_ff.cnt >= t_rec) begin
                    nxt_st.slot = swsl_pkg::SWSL_S_IDLE;
                    nxt_st.cnt  = 16'h0000;
                end
            end
            default: begin
                nxt_st.slot = swsl_pkg::SWSL_S_IDLE;
                nxt_st.oe_n = 1'b1;
            end
        endcase

        if (bit_done) begin
            case (st_ff.phase)
                swsl_pkg::SWSL_P_CMD: begin
                    nxt_st.shreg = rx_byte;
                    nxt_st.bcnt  = st_ff.bcnt + 3'd1;
                    if (st_ff.bcnt == 3'd7) begin
                        nxt_st.idx      = 6'd0;
                        nxt_st.mism     = 1'b0;
                        nxt_st.trip     = 2'd0;
                        nxt_st.od_match = 1'b0;
                        nxt_st.phase    = swsl_pkg::SWSL_P_WAIT;
                        if (rx_byte == `SWSL_CMD_MATCH) begin
                            nxt_st.phase = swsl_pkg::SWSL_P_MATCH;
                        end else if (rx_byte == `SWSL_CMD_OD_MATCH) begin
                            nxt_st.phase    = swsl_pkg::SWSL_P_MATCH;
                            nxt_st.od_match = 1'b1;
                            nxt_st.od_prev  = st_ff.od;
                            nxt_st.od       = 1'b1;
                        end else if (rx_byte == `SWSL_CMD_SEARCH) begin
                            nxt_st.phase = swsl_pkg::SWSL_P_SEARCH;
                        end else if (rx_byte == `SWSL_CMD_SKIP) begin
                            nxt_st.phase = swsl_pkg::SWSL_P_MEM;
                        end else if (rx_byte == `SWSL_CMD_OD_SKIP) begin
                            nxt_st.phase = swsl_pkg::SWSL_P_MEM;
                            nxt_st.od    = 1'b1;
                        end else if (rx_byte == `SWSL_CMD_RESUME && st_ff.rc) begin
                            nxt_st.phase = swsl_pkg::SWSL_P_MEM;
                        end
                    end
                end
                swsl_pkg::SWSL_P_MATCH: begin
                    nxt_st.idx = st_ff.idx + 6'd1;
                    if (bv != id_bit) begin
                        nxt_st.mism = 1'b1;
                    end
                    if (st_ff.idx == 6'd63) begin
                        if (st_ff.mism || bv != id_bit) begin
                            nxt_st.rc    = 1'b0;
                            nxt_st.phase = swsl_pkg::SWSL_P_WAIT;
                            if (st_ff.od_match) begin
                                nxt_st.od = st_ff.od_prev;
                            end
                        end else begin
                            nxt_st.rc    = 1'b1;
                            nxt_st.phase = swsl_pkg::SWSL_P_MEM;
                        end
                    end
                end
                swsl_pkg::SWSL_P_SEARCH: begin
                    if (st_ff.trip != 2'd2) begin
                        nxt_st.trip = st_ff.trip + 2'd1;
                    end else begin
                        nxt_st.trip = 2'd0;
                        if (bv != id_bit) begin
                            nxt_st.rc    = 1'b0;
                            nxt_st.phase = swsl_pkg::SWSL_P_WAIT;
                        end else if (st_ff.idx == 6'd63) begin
                            nxt_st.rc    = 1'b1;
                            nxt_st.phase = swsl_pkg::SWSL_P_MEM;
                        end else begin
                            nxt_st.idx = st_ff.idx + 6'd1;
                        end
                    end
                end
                swsl_pkg::SWSL_P_MEM: begin
                    nxt_st.shreg = rx_byte;
                    nxt_st.bcnt  = st_ff.bcnt + 3'd1;
                    if (st_ff.bcnt == 3'd7) begin
                        // the master cannot be stalled, so a held byte
                        // that is still waiting means data is lost
                        if (st_ff.pend_vld && !fifo_in_ready) begin
                            nxt_st.ovf = 1'b1;
                        end else begin
                            nxt_st.pend     = rx_byte;
                            nxt_st.pend_vld = 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_st.phase = st_ff.phase;
                end
            endcase
        end
        nxt_st.granted = (nxt_st.phase == swsl_pkg::SWSL_P_MEM);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff           <= '0;
            st_ff.slot      <= swsl_pkg::SWSL_S_IDLE;
            st_ff.phase     <= swsl_pkg::SWSL_P_WAIT;
            st_ff.oe_n      <= 1'b1;
            st_ff.line_prev <= 1'b1;
            st_ff.bit_val   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    swsl_fifo #(
        .WIDTH (`SWSL_FIFO_WIDTH),
        .DEPTH (`SWSL_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (st_ff.pend),
        .in_valid  (st_ff.pend_vld),
        .in_ready  (fifo_in_ready),
        .out_data  (mem_data),
        .out_valid (mem_valid),
        .out_ready (mem_ready)
    );

    assign line_out           = st_ff.low_lvl;
    assign line_oe_n          = st_ff.oe_n;
    assign od_flag            = st_ff.od;
    assign resume_select_flag = st_ff.rc;
    assign mem_access         = st_ff.granted;
    assign presence_sent      = st_ff.pres;
    assign mem_overflow       = st_ff.ovf;
endmodule

/* File: testbench/swsl_link_properties.sv */
// pin-level assertions for the slave link
// assumes the cfg header is on the include path; bound to every swsl_link
`timescale 1ns/10ps
`include "swsl_cfg.svh"
module swsl_link_props #(
    parameter logic [15:0] RST_STD_CYC = 16'h1770,
    parameter logic [15:0] OD_CLR_CYC  = 16'h5DC0,
    parameter logic [15:0] PDL_STD_CYC = 16'h1770
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // bus pin
    input wire logic       line_in,
    input wire logic       line_out,
    input wire logic       line_oe_n,
    // byte stream
    input wire logic [7:0] mem_data,
    input wire logic       mem_valid,
    input wire logic       mem_ready,
    // status
    input wire logic       od_flag,
    input wire logic       resume_select_flag,
    input wire logic       mem_access,
    input wire logic       presence_sent
);
    logic [15:0] low_ff;
    logic [15:0] high_ff;
    logic [15:0] drv_ff;
    logic        pres_ff;
    logic [15:0] pdh_cyc;
    logic [15:0] pdl_cyc;

    // saturate so a long idle cannot wrap into a match
    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    assign pdh_cyc = od_flag ? `SWSL_PDH_OD_CYC : `SWSL_PDH_STD_CYC;
    assign pdl_cyc = od_flag ? `SWSL_PDL_OD_CYC : PDL_STD_CYC;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_ff  <= 16'h0000;
            high_ff <= 16'h0000;
            drv_ff  <= 16'h0000;
            pres_ff <= 1'b0;
        end else begin
            low_ff  <= line_in ? 16'h0000 : inc(low_ff);
            high_ff <= line_in ? inc(high_ff) : 16'h0000;
            drv_ff  <= line_oe_n ? 16'h0000 : inc(drv_ff);
            pres_ff <= presence_sent | (pres_ff & ~line_oe_n);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_long_release;
        $rose(line_in) && low_ff >= OD_CLR_CYC + 16'h0002;
    endsequence
    sequence s_od_reset_release;
        $rose(line_in) && od_flag && low_ff > 16'h0320 && low_ff + 16'h0002 < OD_CLR_CYC;
    endsequence

    property p_pres_delay;
        presence_sent |-> high_ff >= pdh_cyc && high_ff <= pdh_cyc + 16'h0006;
    endproperty
    a_pres_delay: assert property (p_pres_delay) else $error("presence delay off");
    property p_pres_len;
        $rose(line_oe_n) && pres_ff |-> drv_ff >= pdl_cyc && drv_ff <= pdl_cyc + 16'h0003;
    endproperty
    a_pres_len: assert property (p_pres_len) else $error("presence length off");
    property p_drive_start;
        $fell(line_oe_n) |-> !line_out && (presence_sent || !line_in);
    endproperty
    a_drive_start: assert property (p_drive_start) else $error("device started a low");
    property p_od_clear;
        s_long_release |-> ##[0:8] !od_flag;
    endproperty
    a_od_clear: assert property (p_od_clear) else $error("overdrive kept after long reset");
    property p_od_keep;
        s_od_reset_release |-> od_flag [*8];
    endproperty
    a_od_keep: assert property (p_od_keep) else $error("overdrive lost on short reset");
    property p_sel_set;
        $rose(resume_select_flag) |-> !$past(mem_access);
    endproperty
    a_sel_set: assert property (p_sel_set) else $error("selection set outside addressing");
    property p_sel_clear;
        $fell(resume_select_flag) |-> !mem_access [*2];
    endproperty
    a_sel_clear: assert property (p_sel_clear) else $error("access kept after deselect");
    property p_rec_quiet;
        $rose(line_in) |-> line_oe_n [*8];
    endproperty
    a_rec_quiet: assert property (p_rec_quiet) else $error("drive during recovery");
    property p_fifo_hold;
        mem_valid && !mem_ready |=> mem_valid && $stable(mem_data);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("byte lost while stalled");
endmodule

bind swsl_link swsl_link_props #(
    .RST_STD_CYC(RST_STD_CYC), .OD_CLR_CYC(OD_CLR_CYC), .PDL_STD_CYC(PDL_STD_CYC)
) chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
    .mem_data(mem_data), .mem_valid(mem_valid), .mem_ready(mem_ready), .od_flag(od_flag),
    .resume_select_flag(resume_select_flag), .mem_access(mem_access), .presence_sent(presence_sent)
);

/* File: testbench/swsl_mst_model.sv */
// bus master model: resets, read and write slots on the open-drain line
// assumes pull-up on the line; device drives low when line_oe_n is 0
`timescale 1ns/10ps
module swsl_mst_model (
    // clock
    input wire logic ref_clk,
    // device pin
    input wire logic line_out,
    input wire logic line_oe_n,
    output logic     line_in
);
    logic pull_low = 1'b0;
    logic fast = 1'b0;

    assign line_in = ~pull_low & (line_oe_n | line_out);

    task automatic hold(input logic lvl, input int n);
        pull_low = lvl;
        repeat (n) @(negedge ref_clk);
    endtask

    // watch for presence, then wait out the window
    // single-device bus, so the shorter window
    task automatic bus_reset(input int low_cyc, output logic seen);
        seen = 1'b0;
        hold(1'b1, low_cyc);
        pull_low = 1'b0;
        for (int i = 0; i < 2000 && !seen; i++) begin
            @(negedge ref_clk);
            seen = !line_in;
        end
        for (int i = 0; i < 8000 && !line_in; i++) @(negedge ref_clk);
        repeat (300) @(negedge ref_clk);
    endtask

    // one released early, zero held past sampling
    task automatic wr_bit(input logic b);
        hold(1'b1, fast ? (b ? 4 : 110) : (b ? 20 : 800));
        hold(1'b0, fast ? 130 : 300);
    endtask

    task automatic rd_bit(output logic b);
        hold(1'b1, fast ? 4 : 20);
        hold(1'b0, fast ? 20 : 200);
        b = line_in;
        for (int i = 0; i < 2000 && !line_in; i++) @(negedge ref_clk);
        hold(1'b0, fast ? 130 : 300);
    endtask

    // one bit per slot, lsb first
    task automatic wr_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) wr_bit(v[i]);
    endtask

    task automatic wr_id(input logic [63:0] v);
        for (int i = 0; i < 8; i++) wr_byte(v[8*i +: 8]);
    endtask
endmodule

/* File: testbench/tb.sv */
// top bench: random bytes through a stalled sink, addressing and speed
// assumes the cfg header is on the include path
`timescale 1ns/10ps
`include "swsl_cfg.svh"
module tb;
    // shortened figures keep the run small
    localparam logic [15:0] RST_CYC = 16'h07D0;
    localparam logic [15:0] CLR_CYC = 16'h0FA0;
    localparam logic [15:0] PDL_CYC = 16'h003C;
    logic        ref_clk = 1'b0;
    logic        rst_n;
    logic        line_in;
    logic        line_out;
    logic        line_oe_n;
    logic [63:0] rom_id;
    logic [7:0]  mem_data;
    logic        mem_valid;
    logic        mem_ready;
    logic        od_flag;
    logic        resume_select_flag;
    logic        mem_access;
    logic        presence_sent;
    logic        mem_overflow;
    logic        seen;
    logic [7:0]  b;
    logic [7:0]  exp_q[$];
    int          failures = 0;
    int          checks = 0;

    always #10 ref_clk = ~ref_clk;

    swsl_link #(.RST_STD_CYC(RST_CYC), .OD_CLR_CYC(CLR_CYC), .PDL_STD_CYC(PDL_CYC)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
        .rom_id(rom_id), .mem_data(mem_data), .mem_valid(mem_valid), .mem_ready(mem_ready),
        .od_flag(od_flag), .resume_select_flag(resume_select_flag), .mem_access(mem_access),
        .presence_sent(presence_sent), .mem_overflow(mem_overflow)
    );
    swsl_mst_model mst_u (.ref_clk(ref_clk), .line_out(line_out), .line_oe_n(line_oe_n), .line_in(line_in));

    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic restart(input int low_cyc);
        mst_u.bus_reset(low_cyc, seen);
        check(seen, 1'b1);
        if (seen !== 1'b1) end_sim();
    endtask

    task automatic wait_valid;
        for (int i = 0; i < 50 && mem_valid !== 1'b1; i++) @(negedge ref_clk);
        if (mem_valid !== 1'b1) begin
            failures++;
            end_sim();
        end
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        mem_ready = 1'b0;
        void'($urandom(32'h0000_936D));
        rom_id = {$urandom(), $urandom()};
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        restart(2100);
        check(od_flag, 1'b0);
        mst_u.wr_byte(`SWSL_CMD_OD_SKIP);
        check(od_flag, 1'b1);
        check(mem_access, 1'b1);
        check(resume_select_flag, 1'b0);
        mst_u.fast = 1'b1;
        // stalled sink: eight queued, one pending, the tenth is lost
        for (int i = 0; i < 10; i++) begin
            b = 8'($urandom());
            if (i < 9) exp_q.push_back(b);
            mst_u.wr_byte(b);
        end
        check(mem_overflow, 1'b1);
        mem_ready = 1'b1;
        foreach (exp_q[i]) begin
            wait_valid();
            check(mem_data, exp_q[i]);
            @(negedge ref_clk);
        end
        check(mem_valid, 1'b0);
        restart(900);
        check(od_flag, 1'b1);
        check(mem_overflow, 1'b0);
        mst_u.wr_byte(`SWSL_CMD_MATCH);
        mst_u.wr_id(rom_id);
        check(resume_select_flag, 1'b1);
        check(mem_access, 1'b1);
        restart(900);
        mst_u.wr_byte(`SWSL_CMD_RESUME);
        check(mem_access, 1'b1);
        // one wrong top bit must deselect
        restart(900);
        mst_u.wr_byte(`SWSL_CMD_OD_MATCH);
        mst_u.wr_id(rom_id ^ 64'h8000_0000_0000_0000);
        check(resume_select_flag, 1'b0);
        check(od_flag, 1'b1);
        check(mem_access, 1'b0);
        restart(900);
        mst_u.wr_byte(`SWSL_CMD_RESUME);
        check(mem_access, 1'b0);
        // search: true bit, complement, then a losing write
        restart(900);
        mst_u.wr_byte(`SWSL_CMD_SEARCH);
        mst_u.rd_bit(seen);
        check(seen, rom_id[0]);
        mst_u.rd_bit(seen);
        check(seen, !rom_id[0]);
        mst_u.wr_bit(!rom_id[0]);
        check(mem_access, 1'b0);
        mst_u.fast = 1'b0;
        restart(4100);
        check(od_flag, 1'b0);
        mst_u.wr_byte(`SWSL_CMD_SKIP);
        check(mem_access, 1'b1);
        // stall the sink so the byte waits to be looked at
        mem_ready = 1'b0;
        b = 8'($urandom());
        mst_u.wr_byte(b);
        wait_valid();
        check(mem_data, b);
        end_sim();
    end
endmodule
